// File: power_runtime_pkg.sv
// Constants for the power-control runtime register bank and riser logic
package power_runtime_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_WAKE_EVENT_STATUS = 6'h00;
  localparam logic [5:0] IDX_WAKE_EVENT_ENABLE = 6'h04;
  localparam logic [5:0] IDX_WAKE_SRC_STATUS_C = 6'h08;
  localparam logic [5:0] IDX_WAKE_SRC_STATUS_B = 6'h09;
  localparam logic [5:0] IDX_WAKE_SRC_STATUS_A = 6'h0a;
  localparam logic [5:0] IDX_WAKE_SRC_ENABLE_C = 6'h0c;
  localparam logic [5:0] IDX_WAKE_SRC_ENABLE_B = 6'h0d;
  localparam logic [5:0] IDX_WAKE_SRC_ENABLE_A = 6'h0e;
  localparam logic [5:0] IDX_LAMP_CONTROL = 6'h10;
  localparam logic [5:0] IDX_KEYBOARD_SCAN_CODE = 6'h11;
  localparam logic [5:0] IDX_FAN_ONE_LOW = 6'h12;
  localparam logic [5:0] IDX_FAN_ONE_HIGH = 6'h13;
  localparam logic [5:0] IDX_FAN_TWO_LOW = 6'h14;
  localparam logic [5:0] IDX_FAN_TWO_HIGH = 6'h15;
  localparam logic [5:0] IDX_WAKE_OUTPUT_CONTROL = 6'h16;
  localparam logic [5:0] IDX_MISC_STATUS = 6'h17;
  localparam logic [5:0] IDX_FORCED_MEDIA_CHANGE = 6'h18;
  localparam logic [5:0] IDX_DISKETTE_RATE_SHADOW = 6'h19;
  localparam logic [5:0] IDX_SERIAL_ONE_SHADOW = 6'h1a;
  localparam logic [5:0] IDX_IRQ_GENERATE_ONE = 6'h1b;
  localparam logic [5:0] IDX_IRQ_GENERATE_TWO = 6'h1c;
  localparam logic [5:0] IDX_SERIAL_TWO_SHADOW = 6'h1d;
  localparam logic [5:0] IDX_SHARED_PIN_CONFIG = 6'h20;
  localparam logic [5:0] IDX_LAST = 6'h20;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_LAMP = 8'h03;
  localparam logic [7:0] RST_WAKE_OUTPUT_CONTROL = 8'h80;
  localparam logic [7:0] RST_FORCED_MEDIA_CHANGE = 8'h01;
  localparam logic [7:0] RST_IRQ_GENERATE = 8'hff;
  localparam logic [4:0] RST_SHARED_PIN_CONFIG = 5'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int WAKE_FLAG_BIT = 0;
  localparam int WAKE_OUT_ENABLE_BIT = 0;
  localparam int PIN_MODE_LSB = 0;
  localparam int PIN_DATA_BIT = 2;
  localparam int PIN_INVERT_BIT = 3;
  localparam int PIN_OPEN_DRAIN_BIT = 4;

  // ----------------------------------------------------------------
  // Shared pin modes and bus answers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PIN_FUNC_ENABLE = 2'h0,
    PIN_GPIO_OUTPUT = 2'h1,
    PIN_GPIO_INPUT = 2'h2,
    PIN_GPIO_INPUT_ALT = 2'h3
  } pin_mode_t;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

// File: power_runtime_regs.sv
// Power-control runtime register bank with riser codec-down reset logic
`timescale 1ns/10ps
`default_nettype none

module power_runtime_regs #(
  parameter int ADDR_W = 32
) (
  // Clock and resets
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic STANDBY_POR,
  // Bank placement
  input wire logic [ADDR_W-1:0] BANK_BASE,
  input wire logic LOGICAL_DEVICE_SELECT_BIT,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  // AXI4-Lite write data
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  // AXI4-Lite read data
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Wake sources, one-cycle event pulses per bit
  input wire logic [7:0] WAKE_SRC_A,
  input wire logic [7:0] WAKE_SRC_B,
  input wire logic [7:0] WAKE_SRC_C,
  // Values held elsewhere, shown read-only
  input wire logic [15:0] FAN_ONE_COUNT,
  input wire logic [15:0] FAN_TWO_COUNT,
  input wire logic [7:0] DISKETTE_RATE_IN,
  input wire logic [7:0] SERIAL_ONE_FIFO_CTRL_IN,
  input wire logic [7:0] SERIAL_TWO_FIFO_CTRL_IN,
  // Register contents used by the rest of the chip
  output logic [7:0] LAMP_CONTROL,
  output logic [7:0] KEYBOARD_WAKE_SCAN_CODE,
  output logic [7:0] WAKE_OUTPUT_CONTROL,
  output logic [7:0] FORCED_MEDIA_CHANGE,
  output logic [15:0] IRQ_GENERATE,
  // Wake signalling
  output logic WAKE_EVENT_OUTPUT_N,
  output logic IRQ,
  // Riser audio slot
  input wire logic AUDIO_LINK_RESET_IN,
  output logic CODEC_DOWN_RESET_OUT,
  // Shared GPIO / codec-down enable pin
  input wire logic SHARED_GPIO_PIN_IN,
  output logic SHARED_GPIO_PIN_OUT,
  output logic SHARED_GPIO_PIN_OE_N,
  output logic SHARED_GPIO_PIN_LEVEL
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  // The decoder needs room for the 0x84-byte window
  if (ADDR_W < 8) begin : g_bad_width
    $error("ADDR_W must be at least 8");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic aw_held_q, w_held_q, bvalid_q, rvalid_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic do_write, do_read;
  logic wr_hit, rd_hit;
  logic [5:0] wr_idx, rd_idx;
  logic [7:0] rd_byte;
  logic [7:0] wake_status_q, wake_enable_q;
  logic [7:0] src_status_a_q, src_status_b_q, src_status_c_q;
  logic [7:0] src_enable_a_q, src_enable_b_q, src_enable_c_q;
  logic [7:0] lamp_q, scan_q, wake_out_ctrl_q, misc_q;
  logic [15:0] fan_one_q, fan_two_q;
  logic [7:0] media_q, irq_gen_one_q, irq_gen_two_q;
  logic [4:0] pin_cfg_q;
  logic wake_set, wake_clr;
  logic [7:0] clr_a, clr_b, clr_c;
  logic enable_level;
  logic gpio_out_level;
  power_runtime_pkg::pin_mode_t pin_mode;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Hit when the bank is selected and the word sits inside the window
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] base);
    logic [ADDR_W-1:0] off;
    off = addr - base;
    addr_hit = !LOGICAL_DEVICE_SELECT_BIT
      && (off[1:0] == 2'h0)
      && (off[ADDR_W-1:2] <= ADDR_W'(power_runtime_pkg::IDX_LAST));
  endfunction

  // Word index relative to the programmed base
  function automatic logic [5:0] addr_idx(input logic [ADDR_W-1:0] addr,
                                          input logic [ADDR_W-1:0] base);
    logic [ADDR_W-1:0] off;
    off = addr - base;
    addr_idx = off[7:2];
  endfunction

  // A process, so the select bit read inside the function retriggers it
  always_comb begin
    wr_hit = addr_hit(awaddr_q, BANK_BASE);
    wr_idx = addr_idx(awaddr_q, BANK_BASE);
    rd_hit = addr_hit(S_AXI_ARADDR, BANK_BASE);
    rd_idx = addr_idx(S_AXI_ARADDR, BANK_BASE);
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channels
  // ----------------------------------------------------------------
  // Address and data are taken in either order; the write happens once
  // both are held and no response is pending.
  assign S_AXI_AWREADY = !aw_held_q;
  assign S_AXI_WREADY = !w_held_q;
  assign do_write = aw_held_q && w_held_q && !bvalid_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;

  // Write handshake state
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= power_runtime_pkg::RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= 8'h00;
      wstrb_q <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && !aw_held_q) begin
        aw_held_q <= 1'b1;
        awaddr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !w_held_q) begin
        w_held_q <= 1'b1;
        wdata_q <= S_AXI_WDATA[7:0]; // Upper lanes have no storage
        wstrb_q <= S_AXI_WSTRB[0];
      end
      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? power_runtime_pkg::RESP_OKAY
                          : power_runtime_pkg::RESP_DECERR;
      end else if (bvalid_q && S_AXI_BREADY) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Byte write enable for one register index
  function automatic logic wr_en(input logic [5:0] idx);
    wr_en = do_write && wr_hit && wstrb_q && (wr_idx == idx);
  endfunction

  // ----------------------------------------------------------------
  // AXI4-Lite read channels
  // ----------------------------------------------------------------
  assign S_AXI_ARREADY = !rvalid_q;
  assign do_read = S_AXI_ARVALID && !rvalid_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;

  // Read mux; reserved offsets fall to the default and read zero
  always_comb begin
    case (rd_idx)
      power_runtime_pkg::IDX_WAKE_EVENT_STATUS: rd_byte = wake_status_q;
      power_runtime_pkg::IDX_WAKE_EVENT_ENABLE: rd_byte = wake_enable_q;
      power_runtime_pkg::IDX_WAKE_SRC_STATUS_C: rd_byte = src_status_c_q;
      power_runtime_pkg::IDX_WAKE_SRC_STATUS_B: rd_byte = src_status_b_q;
      power_runtime_pkg::IDX_WAKE_SRC_STATUS_A: rd_byte = src_status_a_q;
      power_runtime_pkg::IDX_WAKE_SRC_ENABLE_C: rd_byte = src_enable_c_q;
      power_runtime_pkg::IDX_WAKE_SRC_ENABLE_B: rd_byte = src_enable_b_q;
      power_runtime_pkg::IDX_WAKE_SRC_ENABLE_A: rd_byte = src_enable_a_q;
      power_runtime_pkg::IDX_LAMP_CONTROL: rd_byte = lamp_q;
      power_runtime_pkg::IDX_KEYBOARD_SCAN_CODE: rd_byte = scan_q;
      power_runtime_pkg::IDX_FAN_ONE_LOW: rd_byte = fan_one_q[7:0];
      power_runtime_pkg::IDX_FAN_ONE_HIGH: rd_byte = fan_one_q[15:8];
      power_runtime_pkg::IDX_FAN_TWO_LOW: rd_byte = fan_two_q[7:0];
      power_runtime_pkg::IDX_FAN_TWO_HIGH: rd_byte = fan_two_q[15:8];
      power_runtime_pkg::IDX_WAKE_OUTPUT_CONTROL: rd_byte = wake_out_ctrl_q;
      power_runtime_pkg::IDX_MISC_STATUS: rd_byte = misc_q;
      power_runtime_pkg::IDX_FORCED_MEDIA_CHANGE: rd_byte = media_q;
      power_runtime_pkg::IDX_DISKETTE_RATE_SHADOW:
        rd_byte = DISKETTE_RATE_IN;
      power_runtime_pkg::IDX_SERIAL_ONE_SHADOW:
        rd_byte = SERIAL_ONE_FIFO_CTRL_IN;
      power_runtime_pkg::IDX_IRQ_GENERATE_ONE: rd_byte = irq_gen_one_q;
      power_runtime_pkg::IDX_IRQ_GENERATE_TWO: rd_byte = irq_gen_two_q;
      power_runtime_pkg::IDX_SERIAL_TWO_SHADOW:
        rd_byte = SERIAL_TWO_FIFO_CTRL_IN;
      power_runtime_pkg::IDX_SHARED_PIN_CONFIG: rd_byte = {3'h0, pin_cfg_q};
      default: rd_byte = 8'h00;
    endcase
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= power_runtime_pkg::RESP_OKAY;
    end else if (do_read) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      rresp_q <= rd_hit ? power_runtime_pkg::RESP_OKAY
                        : power_runtime_pkg::RESP_DECERR;
    end else if (rvalid_q && S_AXI_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Wake event status (standby domain)
  // ----------------------------------------------------------------
  // Clears are written ones; a new event in the same cycle wins
  always_comb begin
    clr_a = wr_en(power_runtime_pkg::IDX_WAKE_SRC_STATUS_A) ? wdata_q : 8'h00;
    clr_b = wr_en(power_runtime_pkg::IDX_WAKE_SRC_STATUS_B) ? wdata_q : 8'h00;
    clr_c = wr_en(power_runtime_pkg::IDX_WAKE_SRC_STATUS_C) ? wdata_q : 8'h00;
    wake_clr = wr_en(power_runtime_pkg::IDX_WAKE_EVENT_STATUS)
            && wdata_q[power_runtime_pkg::WAKE_FLAG_BIT];
  end
  // Flag sets for any enabled source event, whatever the output enable
  assign wake_set = |(WAKE_SRC_A & src_enable_a_q)
                 || |(WAKE_SRC_B & src_enable_b_q)
                 || |(WAKE_SRC_C & src_enable_c_q);

  // Sticky per-source status and summary flag
  always_ff @(posedge CORE_CLK) begin
    if (STANDBY_POR) begin
      src_status_a_q <= power_runtime_pkg::RST_ZERO;
      src_status_b_q <= power_runtime_pkg::RST_ZERO;
      src_status_c_q <= power_runtime_pkg::RST_ZERO;
      wake_status_q <= power_runtime_pkg::RST_ZERO;
    end else begin
      src_status_a_q <= (src_status_a_q & ~clr_a) | WAKE_SRC_A;
      src_status_b_q <= (src_status_b_q & ~clr_b) | WAKE_SRC_B;
      src_status_c_q <= (src_status_c_q & ~clr_c) | WAKE_SRC_C;
      wake_status_q[power_runtime_pkg::WAKE_FLAG_BIT] <=
        (wake_status_q[power_runtime_pkg::WAKE_FLAG_BIT] && !wake_clr)
        || wake_set;
      wake_status_q[7:1] <= 7'h00;
    end
  end

  // ----------------------------------------------------------------
  // Standby-held control registers
  // ----------------------------------------------------------------
  // Only standby power-on reset touches these; bus reset does not
  always_ff @(posedge CORE_CLK) begin
    if (STANDBY_POR) begin
      wake_enable_q <= power_runtime_pkg::RST_ZERO;
      src_enable_a_q <= power_runtime_pkg::RST_ZERO;
      src_enable_b_q <= power_runtime_pkg::RST_ZERO;
      src_enable_c_q <= power_runtime_pkg::RST_ZERO;
      lamp_q <= power_runtime_pkg::RST_LAMP;
      scan_q <= power_runtime_pkg::RST_ZERO;
      wake_out_ctrl_q <= power_runtime_pkg::RST_WAKE_OUTPUT_CONTROL;
      misc_q <= power_runtime_pkg::RST_ZERO;
      pin_cfg_q <= power_runtime_pkg::RST_SHARED_PIN_CONFIG;
    end else begin
      if (wr_en(power_runtime_pkg::IDX_WAKE_EVENT_ENABLE))
        wake_enable_q <= {7'h00, wdata_q[0]};
      if (wr_en(power_runtime_pkg::IDX_WAKE_SRC_ENABLE_A))
        src_enable_a_q <= wdata_q;
      if (wr_en(power_runtime_pkg::IDX_WAKE_SRC_ENABLE_B))
        src_enable_b_q <= wdata_q;
      if (wr_en(power_runtime_pkg::IDX_WAKE_SRC_ENABLE_C))
        src_enable_c_q <= wdata_q;
      if (wr_en(power_runtime_pkg::IDX_LAMP_CONTROL))
        lamp_q <= wdata_q;
      if (wr_en(power_runtime_pkg::IDX_KEYBOARD_SCAN_CODE))
        scan_q <= wdata_q;
      if (wr_en(power_runtime_pkg::IDX_WAKE_OUTPUT_CONTROL))
        wake_out_ctrl_q <= wdata_q;
      if (wr_en(power_runtime_pkg::IDX_MISC_STATUS))
        misc_q <= wdata_q;
      if (wr_en(power_runtime_pkg::IDX_SHARED_PIN_CONFIG))
        pin_cfg_q <= wdata_q[4:0];
    end
  end

  // Fan counts are sampled every cycle; software writes are dropped
  always_ff @(posedge CORE_CLK) begin
    if (STANDBY_POR) begin
      fan_one_q <= 16'h0000;
      fan_two_q <= 16'h0000;
    end else begin
      fan_one_q <= FAN_ONE_COUNT;
      fan_two_q <= FAN_TWO_COUNT;
    end
  end

  // ----------------------------------------------------------------
  // Main-supply registers
  // ----------------------------------------------------------------
  // Bus reset doubles as main-supply power-on reset for these
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      media_q <= power_runtime_pkg::RST_FORCED_MEDIA_CHANGE;
      irq_gen_one_q <= power_runtime_pkg::RST_IRQ_GENERATE;
      irq_gen_two_q <= power_runtime_pkg::RST_IRQ_GENERATE;
    end else begin
      if (wr_en(power_runtime_pkg::IDX_FORCED_MEDIA_CHANGE))
        media_q <= wdata_q;
      if (wr_en(power_runtime_pkg::IDX_IRQ_GENERATE_ONE))
        irq_gen_one_q <= wdata_q;
      if (wr_en(power_runtime_pkg::IDX_IRQ_GENERATE_TWO))
        irq_gen_two_q <= wdata_q;
    end
  end

  assign LAMP_CONTROL = lamp_q;
  assign KEYBOARD_WAKE_SCAN_CODE = scan_q;
  assign WAKE_OUTPUT_CONTROL = wake_out_ctrl_q;
  assign FORCED_MEDIA_CHANGE = media_q;
  assign IRQ_GENERATE = {irq_gen_two_q, irq_gen_one_q};

  // ----------------------------------------------------------------
  // Wake output and interrupt
  // ----------------------------------------------------------------
  // Clearing the flag releases the output at once
  assign IRQ = wake_status_q[power_runtime_pkg::WAKE_FLAG_BIT]
            && wake_enable_q[power_runtime_pkg::WAKE_OUT_ENABLE_BIT];
  assign WAKE_EVENT_OUTPUT_N = !IRQ;

  // ----------------------------------------------------------------
  // Shared pin and riser codec-down reset
  // ----------------------------------------------------------------
  assign pin_mode = power_runtime_pkg::pin_mode_t'(pin_cfg_q[1:0]);
  assign gpio_out_level = pin_cfg_q[power_runtime_pkg::PIN_DATA_BIT]
                        ^ pin_cfg_q[power_runtime_pkg::PIN_INVERT_BIT];

  // Enable seen by the riser logic for each pin mode
  always_comb begin
    case (pin_mode)
      power_runtime_pkg::PIN_FUNC_ENABLE:
        enable_level = SHARED_GPIO_PIN_IN;
      power_runtime_pkg::PIN_GPIO_OUTPUT:
        enable_level = gpio_out_level;
      default:
        enable_level = 1'b1;
    endcase
  end

  assign CODEC_DOWN_RESET_OUT = AUDIO_LINK_RESET_IN && !enable_level;

  // Pin driver: push-pull drives both levels, open drain only pulls low
  assign SHARED_GPIO_PIN_OUT = gpio_out_level;
  assign SHARED_GPIO_PIN_OE_N = (pin_mode != power_runtime_pkg::PIN_GPIO_OUTPUT)
    || (pin_cfg_q[power_runtime_pkg::PIN_OPEN_DRAIN_BIT]
        && gpio_out_level);

  // General input view of the pin, with the inversion applied
  assign SHARED_GPIO_PIN_LEVEL = SHARED_GPIO_PIN_IN
    ^ pin_cfg_q[power_runtime_pkg::PIN_INVERT_BIT];

endmodule

`default_nettype wire

// File: power_runtime_regs_chk.sv
// Port-level assertions for the power-control runtime bank
`timescale 1ns/10ps
`default_nettype none
module power_runtime_regs_chk #(
  parameter int ADDR_W = 32
) (
  // Clock, reset and placement
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic [ADDR_W-1:0] BANK_BASE,
  input wire logic LOGICAL_DEVICE_SELECT_BIT,
  // Register bus
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // Side signals
  input wire logic [7:0] DISKETTE_RATE_IN,
  input wire logic WAKE_EVENT_OUTPUT_N,
  input wire logic IRQ,
  input wire logic AUDIO_LINK_RESET_IN,
  input wire logic CODEC_DOWN_RESET_OUT
);
  default clocking dc @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  // Read address accepted this edge
  logic ar_go;
  assign ar_go = S_AXI_ARVALID && S_AXI_ARREADY;
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_riser_gate: assert property (
    CODEC_DOWN_RESET_OUT |-> AUDIO_LINK_RESET_IN)
    else $error("codec-down reset high without link reset");
  a_wake_pair: assert property (
    WAKE_EVENT_OUTPUT_N == !IRQ)
    else $error("wake output and irq disagree");
  a_read_answer: assert property (ar_go |=> S_AXI_RVALID)
    else $error("read not answered next cycle");
  a_select_refuse: assert property (
    ar_go && LOGICAL_DEVICE_SELECT_BIT |=>
    S_AXI_RRESP == power_runtime_pkg::RESP_DECERR && S_AXI_RDATA == 32'h0)
    else $error("deselected bank answered");
  a_reserved_zero: assert property (
    ar_go && S_AXI_ARADDR == BANK_BASE + 32'h4 |=> S_AXI_RDATA == 32'h0)
    else $error("reserved offset not zero");
  a_shadow_copy: assert property (
    ar_go && !LOGICAL_DEVICE_SELECT_BIT && S_AXI_ARADDR == BANK_BASE + 32'h64
    |=> S_AXI_RDATA == {24'h0, $past(DISKETTE_RATE_IN)})
    else $error("rate shadow not a copy");
  // Answers must hold while the master stalls
  a_read_hold: assert property (
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read answer dropped");
  a_write_hold: assert property (
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write answer dropped");
endmodule
bind power_runtime_regs power_runtime_regs_chk #(.ADDR_W(ADDR_W))
  power_runtime_regs_chk_inst (.CORE_CLK, .RESET, .BANK_BASE,
  .LOGICAL_DEVICE_SELECT_BIT, .S_AXI_ARADDR, .S_AXI_ARVALID,
  .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID,
  .S_AXI_RREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
  .DISKETTE_RATE_IN, .WAKE_EVENT_OUTPUT_N, .IRQ, .AUDIO_LINK_RESET_IN,
  .CODEC_DOWN_RESET_OUT);
`default_nettype wire

// File: power_runtime_regs_tb_top.sv
// Self-checking bench for the power-control runtime bank
`timescale 1ns/10ps
`default_nettype none
module power_runtime_regs_tb_top;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic CORE_CLK = 0, RESET = 1, STANDBY_POR = 1, IRQ;
  logic [31:0] BANK_BASE = 32'h1000, S_AXI_AWADDR = 32'h0;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_ARADDR = 32'h0, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB = 4'hf;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, r;
  logic LOGICAL_DEVICE_SELECT_BIT = 0, S_AXI_AWVALID = 0, S_AXI_WVALID = 0;
  logic S_AXI_BREADY = 0, S_AXI_ARVALID = 0, S_AXI_RREADY = 0;
  logic AUDIO_LINK_RESET_IN = 0, SHARED_GPIO_PIN_IN = 0, S_AXI_AWREADY;
  logic S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic WAKE_EVENT_OUTPUT_N, CODEC_DOWN_RESET_OUT, SHARED_GPIO_PIN_OUT;
  logic SHARED_GPIO_PIN_OE_N, SHARED_GPIO_PIN_LEVEL, en;
  logic [7:0] WAKE_SRC_A = 8'h0, WAKE_SRC_B = 8'h0, WAKE_SRC_C = 8'h0;
  logic [7:0] DISKETTE_RATE_IN = 8'h19, SERIAL_ONE_FIFO_CTRL_IN = 8'h1a;
  logic [7:0] SERIAL_TWO_FIFO_CTRL_IN = 8'h1d, LAMP_CONTROL;
  logic [7:0] KEYBOARD_WAKE_SCAN_CODE, WAKE_OUTPUT_CONTROL;
  logic [7:0] FORCED_MEDIA_CHANGE;
  logic [15:0] FAN_ONE_COUNT = 16'hb2a1, FAN_TWO_COUNT = 16'hd4c3;
  logic [15:0] IRQ_GENERATE;
  int mismatches = 0, checks = 0, i;
  power_runtime_regs power_runtime_regs_inst (.*);
  // 250 MHz clock
  initial forever #2 CORE_CLK = ~CORE_CLK;
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task summarize;
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // One bus transfer; ready is raised late so the slave must hold
  task automatic acc(input logic w, input logic [5:0] ix,
                     input logic [7:0] d, output logic [31:0] q);
    int n;
    @(posedge CORE_CLK);
    S_AXI_AWADDR <= BANK_BASE + {24'h0, ix, 2'h0};
    S_AXI_ARADDR <= BANK_BASE + {24'h0, ix, 2'h0};
    S_AXI_WDATA <= {24'h0, d};
    S_AXI_AWVALID <= w;
    S_AXI_WVALID <= w;
    S_AXI_ARVALID <= !w;
    for (n = 0; n < 64; n++) begin
      @(posedge CORE_CLK);
      if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        r = S_AXI_BRESP;
        S_AXI_BREADY <= 1'b0;
        break;
      end
      if (S_AXI_RVALID && S_AXI_RREADY) begin
        r = S_AXI_RRESP;
        q = S_AXI_RDATA;
        S_AXI_RREADY <= 1'b0;
        break;
      end
      S_AXI_BREADY <= S_AXI_BVALID;
      S_AXI_RREADY <= S_AXI_RVALID;
    end
    if (n == 64) begin
      mismatches++;
      summarize();
    end
  endtask
  task automatic rd(input logic [5:0] ix, input logic [7:0] e);
    logic [31:0] q;
    acc(1'b0, ix, 8'h0, q);
    cmp(q, {24'h0, e});
    cmp({30'h0, r}, 32'h0);
  endtask
  task automatic wr(input logic [5:0] ix, input logic [7:0] d);
    logic [31:0] q;
    acc(1'b1, ix, d, q);
    cmp({30'h0, r}, 32'h0);
  endtask
  // Pulse one reset domain for a single edge
  task pr(input logic s);
    @(posedge CORE_CLK);
    if (s) STANDBY_POR <= 1'b1;
    else RESET <= 1'b1;
    @(posedge CORE_CLK);
    RESET <= 1'b0;
    STANDBY_POR <= 1'b0;
  endtask
  // One-cycle wake events, then look once the status has landed
  task ev(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    @(posedge CORE_CLK);
    {WAKE_SRC_A, WAKE_SRC_B, WAKE_SRC_C} <= {a, b, c};
    @(posedge CORE_CLK);
    {WAKE_SRC_A, WAKE_SRC_B, WAKE_SRC_C} <= 24'h0;
    @(negedge CORE_CLK);
  endtask
  function automatic logic [7:0] rst_val(input logic [5:0] x);
    case (x)
      6'h10: return 8'h03;
      6'h12: return FAN_ONE_COUNT[7:0];
      6'h13: return FAN_ONE_COUNT[15:8];
      6'h14: return FAN_TWO_COUNT[7:0];
      6'h15: return FAN_TWO_COUNT[15:8];
      6'h16: return 8'h80;
      6'h18: return 8'h01;
      6'h19: return DISKETTE_RATE_IN;
      6'h1a: return SERIAL_ONE_FIFO_CTRL_IN;
      6'h1b, 6'h1c: return 8'hff;
      6'h1d: return SERIAL_TWO_FIFO_CTRL_IN;
      default: return 8'h00;
    endcase
  endfunction
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] q;
    repeat (12) @(posedge CORE_CLK);
    RESET <= 1'b0;
    STANDBY_POR <= 1'b0;
    for (i = 0; i < 32; i++) rd(i[5:0], rst_val(i[5:0]));
    cmp({16'h0, IRQ_GENERATE}, 32'hffff);
    // Writes to reserved and read-only places must change nothing
    for (i = 0; i < 32; i++)
      if (i inside {1, 2, 3, 5, 6, 7, 11, 15, [18:21], 25, 26, [29:31]})
        wr(i[5:0], 8'h5c);
    DISKETTE_RATE_IN <= 8'h3c;
    for (i = 0; i < 32; i++) rd(i[5:0], rst_val(i[5:0]));
    // Each reset domain clears only its own registers
    wr(6'h10, 8'h5a);
    wr(6'h11, 8'h33);
    wr(6'h18, 8'h00);
    wr(6'h1b, 8'h00);
    cmp({24'h0, LAMP_CONTROL}, 32'h5a);
    cmp({8'h0, KEYBOARD_WAKE_SCAN_CODE, WAKE_OUTPUT_CONTROL,
         FORCED_MEDIA_CHANGE}, 32'h0033_8000);
    pr(1'b0);
    rd(6'h10, 8'h5a);
    rd(6'h18, 8'h01);
    rd(6'h1b, 8'hff);
    wr(6'h1c, 8'h12);
    pr(1'b1);
    rd(6'h10, 8'h03);
    rd(6'h11, 8'h00);
    rd(6'h1c, 8'h12);
    // Wake events, enable, masking and write-one clearing
    wr(6'h04, 8'h01);
    wr(6'h0e, 8'h04);
    ev(8'h04, 8'h01, 8'h02);
    cmp({31'h0, IRQ}, 32'h1);
    cmp({31'h0, WAKE_EVENT_OUTPUT_N}, 32'h0);
    rd(6'h0a, 8'h04);
    rd(6'h09, 8'h01);
    rd(6'h08, 8'h02);
    wr(6'h0a, 8'h00);
    rd(6'h0a, 8'h04);
    wr(6'h0a, 8'h04);
    rd(6'h0a, 8'h00);
    wr(6'h00, 8'h01);
    rd(6'h00, 8'h00);
    cmp({31'h0, IRQ}, 32'h0);
    wr(6'h04, 8'h00);
    ev(8'h04, 8'h00, 8'h00);
    cmp({31'h0, IRQ}, 32'h0);
    rd(6'h00, 8'h01);
    // Deselected bank, window edge and a moved base
    LOGICAL_DEVICE_SELECT_BIT <= 1'b1;
    acc(1'b1, 6'h10, 8'h77, q);
    cmp({30'h0, r}, {30'h0, power_runtime_pkg::RESP_DECERR});
    acc(1'b0, 6'h10, 8'h00, q);
    cmp(q, 32'h0);
    cmp({30'h0, r}, {30'h0, power_runtime_pkg::RESP_DECERR});
    LOGICAL_DEVICE_SELECT_BIT <= 1'b0;
    rd(6'h10, 8'h03);
    acc(1'b0, 6'h21, 8'h00, q);
    cmp({30'h0, r}, {30'h0, power_runtime_pkg::RESP_DECERR});
    BANK_BASE <= 32'h2000;
    rd(6'h16, 8'h80);
    // Riser gate over every pin mode, data, inversion and drive type
    for (i = 0; i < 128; i++) begin
      wr(6'h20, {3'h0, i[4:0]});
      @(posedge CORE_CLK);
      AUDIO_LINK_RESET_IN <= i[6];
      SHARED_GPIO_PIN_IN <= i[5];
      @(negedge CORE_CLK);
      en = i[1:0] == 2'h0 ? i[5] : i[1:0] == 2'h1 ? i[2] ^ i[3] : 1'b1;
      cmp({31'h0, CODEC_DOWN_RESET_OUT}, {31'h0, i[6] & !en});
      if (i[1:0] == 2'h1)
        cmp({31'h0, SHARED_GPIO_PIN_OUT}, {31'h0, i[2] ^ i[3]});
      cmp({31'h0, SHARED_GPIO_PIN_OE_N},
          {31'h0, i[1:0] != 2'h1 || (i[4] && (i[2] ^ i[3]))});
      if (i[1])
        cmp({31'h0, SHARED_GPIO_PIN_LEVEL}, {31'h0, i[5] ^ i[3]});
    end
    summarize();
  end
endmodule
`default_nettype wire
